// [logic/arpg_cfg.svh]
`ifndef ARPG_CFG_SVH
`define ARPG_CFG_SVH

// register indices; byte address is four times the index
`define ARPG_IDX_RES0 6'h00
`define ARPG_IDX_RES1 6'h01
`define ARPG_IDX_RES2 6'h02
`define ARPG_IDX_CMP  6'h08
`define ARPG_IDX_SKEW 6'h0A
`define ARPG_IDX_AMP  6'h0B
`define ARPG_IDX_CTRL 6'h0C

// reset values
`define ARPG_CMP_RST  12'h333
`define ARPG_SKEW_RST 24'h000000
`define ARPG_AMP_RST  9'h000
`define ARPG_CTRL_RST 7'h51

// field positions and widths
`define ARPG_SKEW_P2_LSB 12
`define ARPG_CMP_W       12
`define ARPG_AMP_W       9

// output width codes
`define ARPG_WID_S32 2'h3
`define ARPG_WID_Z32 2'h2
`define ARPG_WID_24  2'h1
`define ARPG_WID_16  2'h0

// read increment code for a single register
`define ARPG_RINC_NONE 2'h0

// axi responses
`define ARPG_RESP_OKAY   2'h0
`define ARPG_RESP_DECERR 2'h3

`endif

// [logic/arpg_pkg.sv]
package arpg_pkg;

	// software control bits, high to low as stored in the control word
	typedef struct packed {
		logic [1:0] rd_inc;
		logic       ready_pulse_merge;
		logic       offset_correct_on;
		logic       scale_correct_on;
		logic [1:0] out_width;
	} arpg_ctrl_t;

	// per-channel conversion event from the datapath
	typedef struct packed {
		logic        done;
		logic [23:0] result_code;
	} arpg_conv_t;

	// per-channel correction terms
	typedef struct packed {
		logic [23:0] offset;
		logic [23:0] scale;
	} arpg_corr_t;

endpackage

// [logic/arpg_regs.sv]
`timescale 1ns/100ps
`include "arpg_cfg.svh"

module arpg_regs #(
	parameter int AW = 8
) (
	// clock and reset
	input  wire logic                        aclk,
	input  wire logic                        aresetn,
	// axi4-lite write address
	input  wire logic [AW-1:0]               s_axi_awaddr,
	input  wire logic                        s_axi_awvalid,
	output logic                             s_axi_awready,
	// axi4-lite write data
	input  wire logic [31:0]                 s_axi_wdata,
	input  wire logic [3:0]                  s_axi_wstrb,
	input  wire logic                        s_axi_wvalid,
	output logic                             s_axi_wready,
	// axi4-lite write response
	output logic [1:0]                       s_axi_bresp,
	output logic                             s_axi_bvalid,
	input  wire logic                        s_axi_bready,
	// axi4-lite read address
	input  wire logic [AW-1:0]               s_axi_araddr,
	input  wire logic                        s_axi_arvalid,
	output logic                             s_axi_arready,
	// axi4-lite read data
	output logic [31:0]                      s_axi_rdata,
	output logic [1:0]                       s_axi_rresp,
	output logic                             s_axi_rvalid,
	input  wire logic                        s_axi_rready,
	// converter datapath
	input  wire arpg_pkg::arpg_conv_t [2:0]  conv_in,
	input  wire arpg_pkg::arpg_corr_t [2:0]  corr_in,
	input  wire logic [11:0]                 cmp_bits_in,
	input  wire logic [2:0]                  chan_active,
	// converter control
	output logic [2:0]                       chan_restart,
	output logic [11:0]                      skew_path0_vs_ref,
	output logic [11:0]                      skew_path2_vs_ref,
	output logic [8:0]                       amp_gain_code,
	// data ready
	output logic                             ready_pulse,
	output logic [2:0]                       ready_chan
);

	// ----------------------------------------------------------------
	// storage
	// ----------------------------------------------------------------
	arpg_pkg::arpg_ctrl_t ctrl_reg;
	logic [23:0]          res_reg [3];
	logic [23:0]          snap_reg [3];
	logic [23:0]          stage_reg [3];
	logic [2:0]           seen_reg;
	logic [11:0]          cmp_reg;
	logic [23:0]          skew_reg;
	logic [8:0]           amp_reg;
	logic [2:0]           commit;
	logic [2:0]           seen_next;
	logic [23:0]          corr_val [3];

	// ----------------------------------------------------------------
	// axi write channel state
	// ----------------------------------------------------------------
	logic          aw_have_reg;
	logic          w_have_reg;
	logic [5:0]    waddr_reg;
	logic [31:0]   wdata_reg;
	logic [3:0]    wstrb_reg;
	logic          do_write;
	logic          aw_take;
	logic          w_take;
	logic          ar_take;
	logic [5:0]    ridx;
	logic          w_hit;

	assign aw_take  = s_axi_awvalid && s_axi_awready;
	assign w_take   = s_axi_wvalid && s_axi_wready;
	assign ar_take  = s_axi_arvalid && s_axi_arready;
	assign do_write = aw_have_reg && w_have_reg && !s_axi_bvalid;
	assign ridx     = s_axi_araddr[AW-1:2];

	// ----------------------------------------------------------------
	// correction of raw codes
	// ----------------------------------------------------------------
	// offset add then fractional scale; saturating so overflow never wraps
	function automatic logic [23:0] sat24(input logic signed [25:0] v);
		logic [23:0] r;
		r = v[23:0];
		if (v > 26'sh07FFFFF) begin
			r = 24'h7FFFFF;
		end else if (v < -26'sh0800000) begin
			r = 24'h800000;
		end
		return r;
	endfunction

	function automatic logic [23:0] correct(
		input logic [23:0] raw,
		input logic [23:0] off,
		input logic [23:0] scl,
		input logic        off_on,
		input logic        scl_on
	);
		logic signed [25:0] a;
		logic signed [47:0] p;
		logic [23:0]        b;
		a = 26'(signed'(raw));
		if (off_on) begin
			a = a + 26'(signed'(off));
		end
		b = sat24(a);
		p = signed'(b) * signed'(scl);
		a = 26'(signed'(b));
		if (scl_on) begin
			a = a + 26'(p >>> 23);
		end
		return sat24(a);
	endfunction

	// one corrector per channel, applied on the way into staging
	for (genvar i = 0; i < 3; i++) begin : g_corr
		assign corr_val[i] = correct(conv_in[i].result_code, corr_in[i].offset,
			corr_in[i].scale, ctrl_reg.offset_correct_on,
			ctrl_reg.scale_correct_on);
	end

	// ----------------------------------------------------------------
	// result commit and data ready
	// ----------------------------------------------------------------
	// merged mode waits for every channel, so the set never mixes frames
	always_comb begin
		seen_next = seen_reg;
		commit    = 3'h0;
		for (int i = 0; i < 3; i++) begin
			if (conv_in[i].done) begin
				seen_next[i] = 1'b1;
			end
		end
		if (ctrl_reg.ready_pulse_merge) begin
			if (seen_next == 3'h7) begin
				commit    = 3'h7;
				seen_next = 3'h0;
			end
		end else begin
			for (int i = 0; i < 3; i++) begin
				commit[i] = conv_in[i].done;
			end
			seen_next = 3'h0;
		end
	end

	// staging keeps early finishers until the last one arrives
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			seen_reg <= 3'h0;
			for (int i = 0; i < 3; i++) begin
				stage_reg[i] <= 24'h000000;
			end
		end else begin
			seen_reg <= seen_next;
			for (int i = 0; i < 3; i++) begin
				if (conv_in[i].done) begin
					stage_reg[i] <= corr_val[i];
				end
			end
		end
	end

	// live results; a channel finishing this cycle bypasses staging
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			for (int i = 0; i < 3; i++) begin
				res_reg[i] <= 24'h000000;
			end
		end else begin
			for (int i = 0; i < 3; i++) begin
				if (commit[i]) begin
					res_reg[i] <= conv_in[i].done ? corr_val[i] : stage_reg[i];
				end
			end
		end
	end

	// one pulse per commit cycle: per channel, shared by channels finishing together, or once for the merged set
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			ready_pulse <= 1'b0;
			ready_chan  <= 3'h0;
		end else begin
			ready_pulse <= |commit;
			ready_chan  <= commit;
		end
	end

	// ----------------------------------------------------------------
	// output formatting
	// ----------------------------------------------------------------
	function automatic logic [31:0] fmt(input logic [23:0] v, input logic [1:0] w);
		logic [31:0] r;
		logic [16:0] rnd;
		rnd = 17'(v[23:8]) + 17'(v[7]);
		r   = {8'h00, v};
		unique case (w)
			`ARPG_WID_S32: r = {{8{v[23]}}, v};
			`ARPG_WID_Z32: r = {v, 8'h00};
			`ARPG_WID_24:  r = {8'h00, v};
			`ARPG_WID_16: begin
				// rounding past the top positive code saturates
				if (!v[23] && rnd[15]) begin
					r = 32'h00007FFF;
				end else begin
					r = {16'h0000, rnd[15:0]};
				end
			end
		endcase
		return r;
	endfunction

	// ----------------------------------------------------------------
	// read freeze
	// ----------------------------------------------------------------
	// the value seen at address accept is the newest one, bypassing
	// a commit in that same cycle; linked reads hold the whole set
	function automatic logic [23:0] newest(input int i);
		logic [23:0] r;
		r = res_reg[i];
		if (commit[i]) begin
			r = conv_in[i].done ? corr_val[i] : stage_reg[i];
		end
		return r;
	endfunction

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			for (int i = 0; i < 3; i++) begin
				snap_reg[i] <= 24'h000000;
			end
		end else if (ar_take && ridx == `ARPG_IDX_RES0) begin
			for (int i = 0; i < 3; i++) begin
				snap_reg[i] <= newest(i);
			end
		end
	end

	// ----------------------------------------------------------------
	// axi write path
	// ----------------------------------------------------------------
	// address and data are taken in either order and held until used
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_have_reg   <= 1'b0;
			s_axi_awready <= 1'b0;
			waddr_reg     <= 6'h00;
		end else if (aw_take) begin
			aw_have_reg   <= 1'b1;
			s_axi_awready <= 1'b0;
			waddr_reg     <= s_axi_awaddr[AW-1:2];
		end else if (do_write) begin
			aw_have_reg   <= 1'b0;
		end else if (!aw_have_reg && !s_axi_bvalid) begin
			s_axi_awready <= 1'b1;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			w_have_reg   <= 1'b0;
			s_axi_wready <= 1'b0;
			wdata_reg    <= 32'h00000000;
			wstrb_reg    <= 4'h0;
		end else if (w_take) begin
			w_have_reg   <= 1'b1;
			s_axi_wready <= 1'b0;
			wdata_reg    <= s_axi_wdata;
			wstrb_reg    <= s_axi_wstrb;
		end else if (do_write) begin
			w_have_reg   <= 1'b0;
		end else if (!w_have_reg && !s_axi_bvalid) begin
			s_axi_wready <= 1'b1;
		end
	end

	// result indices decode but accept nothing
	always_comb begin
		unique case (waddr_reg)
			`ARPG_IDX_RES0, `ARPG_IDX_RES1, `ARPG_IDX_RES2,
			`ARPG_IDX_CMP, `ARPG_IDX_SKEW, `ARPG_IDX_AMP,
			`ARPG_IDX_CTRL: w_hit = 1'b1;
			default:        w_hit = 1'b0;
		endcase
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_bvalid <= 1'b0;
			s_axi_bresp  <= `ARPG_RESP_OKAY;
		end else if (do_write) begin
			s_axi_bvalid <= 1'b1;
			s_axi_bresp  <= w_hit ? `ARPG_RESP_OKAY : `ARPG_RESP_DECERR;
		end else if (s_axi_bready) begin
			s_axi_bvalid <= 1'b0;
		end
	end

	// merge byte lanes of the pending write into an old value
	function automatic logic [23:0] lanes(input logic [23:0] old, input logic [31:0] d,
		input logic [3:0] s);
		logic [23:0] r;
		r = old;
		for (int b = 0; b < 3; b++) begin
			if (s[b]) begin
				r[b*8 +: 8] = d[b*8 +: 8];
			end
		end
		return r;
	endfunction

	// ----------------------------------------------------------------
	// writable registers
	// ----------------------------------------------------------------
	// a host write lands for a cycle, then the modulator overwrites it
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			cmp_reg <= `ARPG_CMP_RST;
		end else if (do_write && waddr_reg == `ARPG_IDX_CMP) begin
			cmp_reg <= 12'(lanes({12'h000, cmp_reg}, wdata_reg, wstrb_reg));
		end else begin
			cmp_reg <= cmp_bits_in;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			skew_reg <= `ARPG_SKEW_RST;
		end else if (do_write && waddr_reg == `ARPG_IDX_SKEW) begin
			skew_reg <= lanes(skew_reg, wdata_reg, wstrb_reg);
		end
	end

	// restart pulse even when the value is unchanged
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			chan_restart <= 3'h0;
		end else if (do_write && waddr_reg == `ARPG_IDX_SKEW) begin
			chan_restart <= chan_active;
		end else begin
			chan_restart <= 3'h0;
		end
	end

	// delays count whole master clock periods
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			skew_path0_vs_ref <= 12'h000;
			skew_path2_vs_ref <= 12'h000;
		end else begin
			skew_path0_vs_ref <= skew_reg[`ARPG_SKEW_P2_LSB-1:0];
			skew_path2_vs_ref <= skew_reg[23:`ARPG_SKEW_P2_LSB];
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			amp_reg <= `ARPG_AMP_RST;
		end else if (do_write && waddr_reg == `ARPG_IDX_AMP) begin
			amp_reg <= 9'(lanes({15'h0000, amp_reg}, wdata_reg, wstrb_reg));
		end
	end

	// the stored code reads back as written; the front end sees reserved
	// codes folded to unity so it never needs to know about them
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			amp_gain_code <= `ARPG_AMP_RST;
		end else begin
			for (int i = 0; i < 3; i++) begin
				amp_gain_code[i*3 +: 3] <= (amp_reg[i*3+1 +: 2] == 2'h3) ?
					3'h0 : amp_reg[i*3 +: 3];
			end
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			ctrl_reg <= `ARPG_CTRL_RST;
		end else if (do_write && waddr_reg == `ARPG_IDX_CTRL && wstrb_reg[0]) begin
			ctrl_reg <= wdata_reg[6:0];
		end
	end

	// ----------------------------------------------------------------
	// axi read path
	// ----------------------------------------------------------------
	// later result indices come from the frozen set in linked mode
	function automatic logic [23:0] res_pick(input int i);
		logic [23:0] r;
		r = newest(i);
		if (i != 0 && ctrl_reg.rd_inc != `ARPG_RINC_NONE) begin
			r = snap_reg[i];
		end
		return r;
	endfunction

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid  <= 1'b0;
			s_axi_rdata   <= 32'h00000000;
			s_axi_rresp   <= `ARPG_RESP_OKAY;
		end else if (ar_take) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid  <= 1'b1;
			s_axi_rresp   <= `ARPG_RESP_OKAY;
			unique case (ridx)
				`ARPG_IDX_RES0: s_axi_rdata <= fmt(newest(0), ctrl_reg.out_width);
				`ARPG_IDX_RES1: s_axi_rdata <= fmt(res_pick(1), ctrl_reg.out_width);
				`ARPG_IDX_RES2: s_axi_rdata <= fmt(res_pick(2), ctrl_reg.out_width);
				`ARPG_IDX_CMP:  s_axi_rdata <= {20'h00000, cmp_reg};
				`ARPG_IDX_SKEW: s_axi_rdata <= {8'h00, skew_reg};
				`ARPG_IDX_AMP:  s_axi_rdata <= {23'h000000, amp_reg};
				`ARPG_IDX_CTRL: s_axi_rdata <= {25'h0000000, ctrl_reg};
				default: begin
					s_axi_rdata <= 32'h00000000;
					s_axi_rresp <= `ARPG_RESP_DECERR;
				end
			endcase
		end else if (s_axi_rvalid) begin
			if (s_axi_rready) begin
				s_axi_rvalid <= 1'b0;
			end
		end else begin
			s_axi_arready <= 1'b1;
		end
	end

endmodule // arpg_regs

// [verification/arpg_regs_assertions.sv]
`timescale 1ns/100ps
// --------
// protocol and control checker
// --------
module arpg_chk (
	// clock and reset
	input wire logic        aclk,
	input wire logic        aresetn,
	// bus handshakes
	input wire logic        s_axi_awvalid,
	input wire logic        s_axi_awready,
	input wire logic        s_axi_wvalid,
	input wire logic        s_axi_wready,
	input wire logic        s_axi_bvalid,
	input wire logic        s_axi_arvalid,
	input wire logic        s_axi_arready,
	input wire logic        s_axi_rvalid,
	input wire logic        s_axi_rready,
	input wire logic [31:0] s_axi_rdata,
	// converter side
	input wire logic [2:0]  chan_restart,
	input wire logic [11:0] skew_path0_vs_ref,
	input wire logic [11:0] skew_path2_vs_ref,
	input wire logic [8:0]  amp_gain_code,
	input wire logic        ready_pulse,
	input wire logic [2:0]  ready_chan
);
	default clocking @(posedge aclk); endclocking
	default disable iff (!aresetn);

	// read answer one cycle after the address is taken
	property p_rd_lat;
		s_axi_arvalid && s_axi_arready |=> s_axi_rvalid;
	endproperty
	a_rd_lat: assert property (p_rd_lat)
		else $error("read answer late");
	// a stalled read keeps one stable word on the bus
	property p_rd_hold;
		s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
	endproperty
	a_rd_hold: assert property (p_rd_hold)
		else $error("read word moved while stalled");
	// write response two cycles after both halves are taken
	property p_wr_lat;
		s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##2 s_axi_bvalid;
	endproperty
	a_wr_lat: assert property (p_wr_lat)
		else $error("write answer late");
	// no new write accepted while a response is pending
	property p_wr_excl;
		s_axi_bvalid |-> !s_axi_awready && !s_axi_wready;
	endproperty
	a_wr_excl: assert property (p_wr_excl)
		else $error("write accepted during response");
	// restart is a single-cycle pulse
	property p_restart;
		chan_restart != 3'h0 |=> chan_restart == 3'h0;
	endproperty
	a_restart: assert property (p_restart)
		else $error("restart pulse too long");
	// delays only move with a completed write; outputs trail the response by one edge
	property p_skew_wr;
		$changed({skew_path2_vs_ref, skew_path0_vs_ref}) |->
			$past(s_axi_bvalid) && !$past(s_axi_bvalid, 2);
	endproperty
	a_skew_wr: assert property (p_skew_wr)
		else $error("delay moved without write");
	// reserved gain codes never reach the amplifiers
	property p_gain_fold;
		amp_gain_code[2:1] != 2'h3 && amp_gain_code[5:4] != 2'h3 && amp_gain_code[8:7] != 2'h3;
	endproperty
	a_gain_fold: assert property (p_gain_fold)
		else $error("reserved gain code applied");
	// ready pulse and channel mask go together
	property p_ready_tie;
		(ready_chan != 3'h0) == ready_pulse;
	endproperty
	a_ready_tie: assert property (p_ready_tie)
		else $error("ready pulse and mask differ");
endmodule // arpg_chk

bind arpg_regs arpg_chk arpg_chk_inst (.aclk, .aresetn, .s_axi_awvalid, .s_axi_awready,
	.s_axi_wvalid, .s_axi_wready, .s_axi_bvalid, .s_axi_arvalid, .s_axi_arready,
	.s_axi_rvalid, .s_axi_rready, .s_axi_rdata, .chan_restart, .skew_path0_vs_ref,
	.skew_path2_vs_ref, .amp_gain_code, .ready_pulse, .ready_chan);

// [verification/arpg_dp_model.sv]
`timescale 1ns/100ps
// --------
// converter datapath stand-in
// --------
module arpg_dp_model (
	// clock and reset
	input  wire logic                  aclk,
	input  wire logic                  aresetn,
	// bench commands
	input  wire logic [2:0]            fire,
	input  wire logic [23:0]           code,
	// conversion events
	output arpg_pkg::arpg_conv_t [2:0] conv_in
);
	// done a cycle after the request; code toggles when not valid so stale data shows
	always_ff @(posedge aclk) begin
		for (int i = 0; i < 3; i++) begin
			conv_in[i].done <= aresetn & fire[i];
			if (!aresetn)
				conv_in[i].result_code <= 24'h000000;
			else if (fire[i])
				conv_in[i].result_code <= code;
			else
				conv_in[i].result_code <= ~conv_in[i].result_code;
		end
	end
endmodule // arpg_dp_model

// [verification/arpg_regs_test.sv]
`timescale 1ns/100ps
`include "arpg_cfg.svh"
module arpg_regs_test;
	// --------
	// signals
	// --------
	logic		aclk, aresetn, ready_pulse;
	logic [7:0]	s_axi_awaddr, s_axi_araddr;
	logic		s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
	logic		s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	logic [31:0]	s_axi_wdata, s_axi_rdata;
	logic [31:0]	wexp [0:3];
	logic [3:0]	s_axi_wstrb;
	logic [1:0]	s_axi_bresp, s_axi_rresp;
	logic [11:0]	cmp_bits_in, skew_path0_vs_ref, skew_path2_vs_ref;
	logic [2:0]	chan_active, chan_restart, ready_chan, fire, rst_seen, rdy_seen;
	logic [8:0]	amp_gain_code, g;
	logic [23:0]	code;
	arpg_pkg::arpg_conv_t [2:0]	conv_in;
	arpg_pkg::arpg_corr_t [2:0]	corr_in;
	int		error_cnt, checked, cyc, rdy_cnt;

	// clock
	initial begin
		aclk = 1'b0;
		forever #5 aclk = ~aclk;
	end

	arpg_regs #(.AW(8)) arpg_regs_inst (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid,
		.s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
		.s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
		.s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
		.conv_in, .corr_in, .cmp_bits_in, .chan_active, .chan_restart, .skew_path0_vs_ref,
		.skew_path2_vs_ref, .amp_gain_code, .ready_pulse, .ready_chan);
	arpg_dp_model arpg_dp_model_inst (.aclk, .aresetn, .fire, .code, .conv_in);

	// --------
	// helpers
	// --------
	function automatic logic [7:0] ba(input logic [5:0] i);
		return {i, 2'b00};
	endfunction
	// control word with a single-register read increment
	function automatic logic [31:0] ctl(input logic m, input logic o, input logic [1:0] w);
		return {25'h0, `ARPG_RINC_NONE, m, o, 1'b0, w};
	endfunction
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checked++;
		if (got !== exp) begin
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
			error_cnt++;
		end
	endtask
	// bus write; both halves offered together, each dropped once taken
	task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		do begin
			@(posedge aclk);
			if (s_axi_awready) s_axi_awvalid <= 1'b0;
			if (s_axi_wready) s_axi_wvalid <= 1'b0;
		end while (s_axi_awvalid || s_axi_wvalid);
		do @(posedge aclk); while (!s_axi_bvalid);
		s_axi_bready <= 1'b0;
		chk({30'h0, s_axi_bresp}, {30'h0, er});
	endtask
	// bus read; slow stalls the data channel that many cycles
	task automatic rc(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er,
			input int slow);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= (slow == 0);
		do @(posedge aclk); while (!s_axi_arready);
		s_axi_arvalid <= 1'b0;
		repeat (slow) @(posedge aclk);
		s_axi_rready <= 1'b1;
		do @(posedge aclk); while (!s_axi_rvalid);
		s_axi_rready <= 1'b0;
		chk(s_axi_rdata, e);
		chk({30'h0, s_axi_rresp}, {30'h0, er});
	endtask
	// one conversion per masked channel, then let it commit
	task automatic shot(input logic [2:0] m, input logic [23:0] c);
		fire <= m;
		code <= c;
		@(posedge aclk);
		fire <= 3'h0;
		repeat (3) @(posedge aclk);
	endtask
	task close_out;
		$display("checks %0d mismatches %0d", checked, error_cnt);
		if (error_cnt == 0 && checked > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask

	// watch restart and ready pulses
	always @(posedge aclk) begin
		if (chan_restart != 3'h0) rst_seen <= chan_restart;
		if (ready_pulse === 1'b1) begin
			rdy_cnt <= rdy_cnt + 1;
			rdy_seen <= ready_chan;
		end
	end

	// hang guard; the sequence needs well under a thousand cycles
	initial begin
		cyc = 0;
		while (cyc < 5000) begin
			@(posedge aclk);
			cyc++;
		end
		error_cnt++;
		$display("wrong value at %0t: timeout", $time);
		close_out;
	end

	// --------
	// tests
	// --------
	initial begin
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h00;
		{s_axi_awaddr, s_axi_araddr, s_axi_wdata, fire, code} = 75'h0;
		{error_cnt, checked, rdy_cnt, rst_seen, rdy_seen} = 0;
		s_axi_wstrb = 4'hF;
		cmp_bits_in = 12'h000;
		chan_active = 3'h5;
		corr_in = '0;
		wexp = '{32'h00001235, 32'h00800080, 32'h80008000, 32'hFF800080};
		aresetn = 1'b0;
		repeat (3) @(posedge aclk);
		aresetn <= 1'b1;
		@(posedge aclk);
		rc(ba(`ARPG_IDX_SKEW), 32'h0, `ARPG_RESP_OKAY, 0);
		rc(ba(`ARPG_IDX_AMP), 32'h0, `ARPG_RESP_OKAY, 0);
		rc(ba(`ARPG_IDX_CTRL), {25'h0, `ARPG_CTRL_RST}, `ARPG_RESP_OKAY, 0);
		rc(8'h0C, 32'h0, `ARPG_RESP_DECERR, 0);
		wr(8'h24, 32'h1, `ARPG_RESP_DECERR);
		$display("test reset done");
		// snapshot is only ever read here, never written
		cmp_bits_in <= 12'hA5C;
		// the snapshot register needs one edge to pick the new bits up
		@(posedge aclk);
		rc(ba(`ARPG_IDX_CMP), 32'h00000A5C, `ARPG_RESP_OKAY, 2);
		$display("test snapshot done");
		// every skew write restarts the running channels, same value or not
		for (int k = 0; k < 2; k++) begin
			chan_active <= k ? 3'h2 : 3'h5;
			wr(ba(`ARPG_IDX_SKEW), 32'hFFABC123, `ARPG_RESP_OKAY);
			rc(ba(`ARPG_IDX_SKEW), 32'h00ABC123, `ARPG_RESP_OKAY, 0);
			chk({20'h0, skew_path2_vs_ref}, 32'hABC);
			chk({20'h0, skew_path0_vs_ref}, 32'h123);
			chk({29'h0, rst_seen}, k ? 32'h2 : 32'h5);
		end
		$display("test skew done");
		for (int c = 0; c < 8; c++) begin
			g = {c[2:0], c[2:0], c[2:0]};
			wr(ba(`ARPG_IDX_AMP), {23'h7FFFFF, g}, `ARPG_RESP_OKAY);
			rc(ba(`ARPG_IDX_AMP), {23'h0, g}, `ARPG_RESP_OKAY, 0);
			chk({23'h0, amp_gain_code}, (c > 5) ? 32'h0 : {23'h0, g});
		end
		$display("test gain done");
		wr(ba(`ARPG_IDX_CTRL), ctl(1'b0, 1'b0, `ARPG_WID_24), `ARPG_RESP_OKAY);
		rdy_cnt = 0;
		shot(3'h1, 24'h123456);
		rc(ba(`ARPG_IDX_RES0), 32'h00123456, `ARPG_RESP_OKAY, 0);
		chk(rdy_cnt, 32'h1);
		chk({29'h0, rdy_seen}, 32'h1);
		wr(ba(`ARPG_IDX_RES0), 32'h00FFFFFF, `ARPG_RESP_OKAY);
		rc(ba(`ARPG_IDX_RES0), 32'h00123456, `ARPG_RESP_OKAY, 1);
		for (int w = 0; w < 4; w++) begin
			wr(ba(`ARPG_IDX_CTRL), ctl(1'b0, 1'b0, w[1:0]), `ARPG_RESP_OKAY);
			shot(3'h2, (w == 0) ? 24'h1234C0 : 24'h800080);
			rc(ba(`ARPG_IDX_RES1), wexp[w], `ARPG_RESP_OKAY, w);
		end
		$display("test results done");
		corr_in[0].offset <= 24'h000010;
		wr(ba(`ARPG_IDX_CTRL), ctl(1'b0, 1'b1, `ARPG_WID_24), `ARPG_RESP_OKAY);
		shot(3'h1, 24'h000100);
		rc(ba(`ARPG_IDX_RES0), 32'h00000110, `ARPG_RESP_OKAY, 0);
		$display("test correction done");
		// merged: nothing commits until the last channel finishes
		wr(ba(`ARPG_IDX_CTRL), ctl(1'b1, 1'b0, `ARPG_WID_24), `ARPG_RESP_OKAY);
		rdy_cnt = 0;
		shot(3'h1, 24'h111111);
		rc(ba(`ARPG_IDX_RES0), 32'h00000110, `ARPG_RESP_OKAY, 0);
		shot(3'h2, 24'h222222);
		shot(3'h4, 24'h333333);
		chk(rdy_cnt, 32'h1);
		chk({29'h0, rdy_seen}, 32'h7);
		for (int i = 0; i < 3; i++)
			rc(ba(i[5:0]), {8'h0, {6{i[3:0] + 4'h1}}}, `ARPG_RESP_OKAY, 0);
		$display("test merge done");
		// linked reads: index 0 freezes the set, later indices return the frozen words
		wr(ba(`ARPG_IDX_CTRL), ctl(1'b1, 1'b0, `ARPG_WID_24) | 32'h00000040,
			`ARPG_RESP_OKAY);
		rc(ba(`ARPG_IDX_RES0), 32'h00111111, `ARPG_RESP_OKAY, 0);
		shot(3'h7, 24'h444444);
		rc(ba(`ARPG_IDX_RES1), 32'h00222222, `ARPG_RESP_OKAY, 0);
		rc(ba(`ARPG_IDX_RES0), 32'h00444444, `ARPG_RESP_OKAY, 0);
		rc(ba(`ARPG_IDX_RES2), 32'h00444444, `ARPG_RESP_OKAY, 0);
		$display("test linked done");
		close_out;
	end
endmodule // arpg_regs_test
